// >>> shared/power_mode_pkg.sv
// Purpose: constants, modes and carrier for the power mode clock controller
// Assumes: one 125 MHz bus clock, 32-bit AHB-Lite register access
// Notes: oscillator cycle counts are counted on synchronised oscillator edges
package power_mode_pkg;

  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [3:0] CLK_MODE_OFS = 4'h0; // clock_mode_register
  localparam logic [3:0] CTRL_OFS = 4'h4; // idle clock keep
  localparam logic [3:0] STATUS_OFS = 4'h8; // flags and current mode

  // ****************************************
  // field positions
  // ****************************************
  localparam int DIV_LSB = 5; // clock_divider_select [7:5]
  localparam int SLOW_RDY_BIT = 3; // slow_osc_ready, read only
  localparam int FAST_RDY_BIT = 2; // fast_osc_ready, read only
  localparam int IDLE_EN_BIT = 1; // idle_enable
  localparam int FAST_SEL_BIT = 0; // fast_clock_select
  localparam int KEEP_BIT = 7; // idle_clock_keep
  localparam int PDF_BIT = 0; // power_down_flag
  localparam int TO_BIT = 1; // watchdog_expired_flag
  localparam int MODE_LSB = 2; // current mode [4:2]

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic IDLE_EN_RST = 1'b1;
  localparam logic FAST_SEL_RST = 1'b1;
  localparam logic KEEP_RST = 1'b0;

  // ****************************************
  // selection codes and timing counts
  // ****************************************
  localparam logic [2:0] DIV_SLOW_MAX = 3'h1; // 000 and 001 pick the slow clock
  localparam logic [3:0] DIV_LOG_BASE = 4'h8; // code c divides by 2**(8-c)
  localparam logic [10:0] FAST_READY_CYC = 11'h400; // 1024 fast cycles
  localparam logic [1:0] SLOW_READY_CYC = 2'h2; // ready within 1..2 slow cycles

  // operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_SLOW,
    MODE_IDLE_STOPPED,
    MODE_IDLE_RUNNING,
    MODE_SLEEP
  } mode_e;

  // clock gating levels and pulses toward the rest of the chip
  typedef struct packed {
    logic cpu_run; // cpu clock enabled
    logic sys_run; // system clock reaches peripherals
    logic time_base_run; // time-base clock enabled
    logic slow_run; // slow clock and watchdog clock
    logic fast_osc_on; // fast rc oscillator enable
    logic sys_tick; // one pulse per system clock period
    logic wdt_clear; // one-cycle watchdog clear
  } clock_ctrl_s;

endpackage

// >>> rtl/power_mode_clock_controller.sv
// Purpose: operating mode, system clock source and divider, oscillator ready flags
// Assumes: oscillators toggle pins far slower than hclk; halt/wake come from hclk logic
// Notes: the system clock is produced as a tick pulse train on hclk
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - five modes, cpu stopped in three
// - normal: fast clock divided 1 to 64
// - slow: slow clock, fast oscillator off
// - halt, idle disabled: enter sleep
// - halt, idle, no keep: idle clock stopped
// - halt, idle, keep: idle clock running
// - registers switch speed, only halt enters low power
// - slow chosen: fast oscillator and dividers stop
// - slow switch waits for slow oscillator ready
// - sleep: system and time-base clocks stop
// - low power holds memory, registers, ports
// - low power entry clears watchdog counter
// - entry sets power down, clears expired
// - idle stopped: time-base and slow run
// - idle running: system, time-base, slow run
// - divider codes select slow or fast/64../2
// - fast ready after 1024 cycles, low off
// - slow ready low in sleep, 1-2 cycles
module power_mode_clock_controller (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fast_osc_pin,
  input wire logic slow_osc_pin,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic clr_wdt_req,
  input wire logic wdt_timeout,
  output power_mode_pkg::clock_ctrl_s clk_ctrl,
  output power_mode_pkg::mode_e mode
);

  // ****************************************
  // oscillator pin synchronisers
  // ****************************************
  logic [1:0] s1_q, s2_q, s3_q; // bit 0 fast, bit 1 slow
  logic [1:0] lvl_q; // filtered oscillator level
  logic [1:0] agree; // second and third stages match
  logic [1:0] rise; // filtered rising edge
  logic fast_edge, slow_edge;

  // three stages; only the second reads the first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      lvl_q <= 2'h0;
    end else if (ce) begin
      s1_q <= {slow_osc_pin, fast_osc_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (agree & s3_q) | (~agree & lvl_q);
    end
  end

  assign agree = ~(s2_q ^ s3_q);
  assign rise = agree & s3_q & ~lvl_q;
  assign fast_edge = rise[0];
  assign slow_edge = rise[1];

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic [2:0] div_q; // clock_divider_select
  logic idle_en_q; // idle_enable
  logic fast_sel_q; // fast_clock_select
  logic keep_q; // idle_clock_keep
  logic pdf_q; // power_down_flag
  logic to_q; // watchdog_expired_flag
  logic fast_rdy_q, slow_rdy_q;
  power_mode_pkg::mode_e mode_q;
  logic accept; // address phase taken
  logic wr_pend_q; // write data phase follows
  logic [3:0] wr_ofs_q;
  logic [31:0] rd_word; // read mux result
  logic [31:0] hrdata_q;

  // stall the bus while frozen so no transfer is lost
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign accept = ce & hsel & hready & htrans[1];

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0;
    unique case (haddr[3:0])
      power_mode_pkg::CLK_MODE_OFS: begin
        rd_word[power_mode_pkg::DIV_LSB +: 3] = div_q;
        rd_word[power_mode_pkg::SLOW_RDY_BIT] = slow_rdy_q;
        rd_word[power_mode_pkg::FAST_RDY_BIT] = fast_rdy_q;
        rd_word[power_mode_pkg::IDLE_EN_BIT] = idle_en_q;
        rd_word[power_mode_pkg::FAST_SEL_BIT] = fast_sel_q;
      end
      power_mode_pkg::CTRL_OFS: begin
        rd_word[power_mode_pkg::KEEP_BIT] = keep_q;
      end
      power_mode_pkg::STATUS_OFS: begin
        rd_word[power_mode_pkg::PDF_BIT] = pdf_q;
        rd_word[power_mode_pkg::TO_BIT] = to_q;
        rd_word[power_mode_pkg::MODE_LSB +: 3] = mode_q;
      end
      default: rd_word = 32'h0;
    endcase
  end

  // capture the address phase; read data is ready in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 4'h0;
      hrdata_q <= 32'h0;
    end else if (ce) begin
      wr_pend_q <= accept & hwrite;
      if (accept) begin
        wr_ofs_q <= haddr[3:0];
        hrdata_q <= hwrite ? 32'h0 : rd_word;
      end
    end
  end

  // software controls; mode speed changes only through these bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= power_mode_pkg::DIV_RST;
      idle_en_q <= power_mode_pkg::IDLE_EN_RST;
      fast_sel_q <= power_mode_pkg::FAST_SEL_RST;
      keep_q <= power_mode_pkg::KEEP_RST;
    end else if (ce && wr_pend_q) begin
      if (wr_ofs_q == power_mode_pkg::CLK_MODE_OFS) begin
        div_q <= hwdata[power_mode_pkg::DIV_LSB +: 3];
        idle_en_q <= hwdata[power_mode_pkg::IDLE_EN_BIT];
        fast_sel_q <= hwdata[power_mode_pkg::FAST_SEL_BIT];
      end
      if (wr_ofs_q == power_mode_pkg::CTRL_OFS) begin
        keep_q <= hwdata[power_mode_pkg::KEEP_BIT];
      end
    end
  end

  // ****************************************
  // clock source and divider
  // ****************************************
  logic running; // cpu clocked
  logic req_fast; // software asks for the fast source
  logic [2:0] req_log; // requested log2 divide
  logic src_fast_q; // source in use
  logic [2:0] cur_log_q; // divide in use
  logic [5:0] cnt_q; // fast edges within one period
  logic tick_now; // period boundary of current source
  logic boundary; // safe point to change source
  logic fast_on;
  logic sys_tick_q;

  assign running = (mode_q == power_mode_pkg::MODE_NORMAL) | (mode_q == power_mode_pkg::MODE_SLOW);
  assign req_fast = fast_sel_q | (div_q > power_mode_pkg::DIV_SLOW_MAX);
  assign req_log = fast_sel_q ? 3'h0 : 3'(power_mode_pkg::DIV_LOG_BASE - {1'b0, div_q});
  assign tick_now = src_fast_q ? (fast_edge && cnt_q == 6'((7'h1 << cur_log_q) - 7'h1)) : slow_edge;
  // a stopped source has no pulse to cut, so it may be swapped at once
  assign boundary = tick_now | (src_fast_q & ~fast_on);

  // fast oscillator runs only while the fast source is wanted or in use
  assign fast_on = (running & (req_fast | src_fast_q))
    | (mode_q == power_mode_pkg::MODE_IDLE_RUNNING & src_fast_q);

  // the new source starts a whole period at a boundary, never a runt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_fast_q <= 1'b1;
      cur_log_q <= 3'h0;
      cnt_q <= 6'h0;
    end else if (ce) begin
      if (boundary && (req_fast || slow_rdy_q)) begin
        src_fast_q <= req_fast;
        cur_log_q <= req_log;
        cnt_q <= 6'h0;
      end else if (tick_now) begin
        cnt_q <= 6'h0; // a held-off switch must not stretch the period
      end else if (src_fast_q && fast_edge) begin
        cnt_q <= cnt_q + 6'h1;
      end
    end
  end

  // system clock pulses reach logic only in modes that keep it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_tick_q <= 1'b0;
    end else if (ce) begin
      sys_tick_q <= tick_now & (running | mode_q == power_mode_pkg::MODE_IDLE_RUNNING);
    end
  end

  // ****************************************
  // oscillator ready flags
  // ****************************************
  logic [10:0] fcnt_q; // fast cycles since enable
  logic [1:0] scnt_q; // slow cycles since leaving sleep

  // fast ready: cleared while the oscillator is off and at the halt that stops it, set after 1024 cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fcnt_q <= 11'h0;
      fast_rdy_q <= 1'b0;
    end else if (ce) begin
      if (!fast_on || (halt_go && !(idle_en_q && keep_q))) begin
        fcnt_q <= 11'h0;
        fast_rdy_q <= 1'b0;
      end else if (fast_edge && !fast_rdy_q) begin
        fcnt_q <= fcnt_q + 11'h1;
        fast_rdy_q <= (fcnt_q + 11'h1) == power_mode_pkg::FAST_READY_CYC;
      end
    end
  end

  // slow ready: low in sleep, high on the second slow edge after
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scnt_q <= 2'h0;
      slow_rdy_q <= 1'b0;
    end else if (ce) begin
      if (mode_q == power_mode_pkg::MODE_SLEEP) begin
        scnt_q <= 2'h0;
        slow_rdy_q <= 1'b0;
      end else if (slow_edge && !slow_rdy_q) begin
        scnt_q <= scnt_q + 2'h1;
        slow_rdy_q <= (scnt_q + 2'h1) == power_mode_pkg::SLOW_READY_CYC;
      end
    end
  end

  // ****************************************
  // operating mode and halt effects
  // ****************************************
  logic halt_go; // halt taken from a running mode
  logic wdt_clear_q;

  assign halt_go = halt_req & running;

  // halt picks the low-power mode; wake returns to the source in use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= power_mode_pkg::MODE_NORMAL;
    end else if (ce) begin
      if (halt_go) begin
        if (!idle_en_q) begin
          mode_q <= power_mode_pkg::MODE_SLEEP;
        end else if (keep_q) begin
          mode_q <= power_mode_pkg::MODE_IDLE_RUNNING;
        end else begin
          mode_q <= power_mode_pkg::MODE_IDLE_STOPPED;
        end
      end else if (running || wake_req) begin
        mode_q <= src_fast_q ? power_mode_pkg::MODE_NORMAL : power_mode_pkg::MODE_SLOW;
      end
    end
  end

  // status flags; a set arriving with its clear wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdf_q <= 1'b0;
      to_q <= 1'b0;
      wdt_clear_q <= 1'b0;
    end else if (ce) begin
      wdt_clear_q <= halt_go;
      if (halt_go) begin
        pdf_q <= 1'b1;
      end else if (clr_wdt_req) begin
        pdf_q <= 1'b0;
      end
      if (wdt_timeout) begin
        to_q <= 1'b1;
      end else if (halt_go) begin
        to_q <= 1'b0;
      end
    end
  end

  // cpu gating freezes memory, registers and ports while halted
  assign clk_ctrl.cpu_run = running;
  assign clk_ctrl.sys_run = running | (mode_q == power_mode_pkg::MODE_IDLE_RUNNING);
  assign clk_ctrl.time_base_run = mode_q != power_mode_pkg::MODE_SLEEP;
  assign clk_ctrl.slow_run = 1'b1;
  assign clk_ctrl.fast_osc_on = fast_on;
  assign clk_ctrl.sys_tick = sys_tick_q;
  assign clk_ctrl.wdt_clear = wdt_clear_q;
  assign mode = mode_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sleep_entry_a: assert property (ce && halt_go && !idle_en_q |=> mode_q == power_mode_pkg::MODE_SLEEP)
    else $error("halt with idle disabled did not sleep");
  idle_stop_a: assert property (ce && halt_go && idle_en_q && !keep_q
    |=> mode_q == power_mode_pkg::MODE_IDLE_STOPPED && !clk_ctrl.sys_run && clk_ctrl.time_base_run)
    else $error("idle stopped entry wrong");
  idle_run_a: assert property (ce && halt_go && idle_en_q && keep_q
    |=> mode_q == power_mode_pkg::MODE_IDLE_RUNNING && clk_ctrl.sys_run && !clk_ctrl.cpu_run)
    else $error("idle running entry wrong");
  halt_flags_a: assert property (ce && halt_go && !wdt_timeout |=> pdf_q && !to_q && clk_ctrl.wdt_clear)
    else $error("halt did not update flags");
  sleep_clocks_a: assert property (mode_q == power_mode_pkg::MODE_SLEEP
    |-> !clk_ctrl.sys_run && !clk_ctrl.time_base_run && !fast_rdy_q && clk_ctrl.slow_run)
    else $error("clocks wrong in sleep");
  slow_off_a: assert property (mode_q == power_mode_pkg::MODE_SLOW && !req_fast |-> !clk_ctrl.fast_osc_on)
    else $error("fast oscillator on in slow mode");
  slow_switch_a: assert property (ce && src_fast_q && !req_fast && !slow_rdy_q |=> src_fast_q)
    else $error("switched to slow before ready");
  src_change_a: assert property ($changed(src_fast_q) |-> $past(boundary))
    else $error("source changed off a boundary");
  slow_ready_a: assert property (ce && $past(ce) && slow_edge && mode_q != power_mode_pkg::MODE_SLEEP
    && scnt_q == 2'h1 |=> slow_rdy_q)
    else $error("slow ready late");
  div1_tick_a: assert property (ce && src_fast_q && cur_log_q == 3'h0 && fast_edge && running
    |=> sys_tick_q)
    else $error("undivided fast clock missed a tick");

  sleep_c: cover property (ce && halt_go && !idle_en_q);
  idle_run_c: cover property (mode_q == power_mode_pkg::MODE_IDLE_RUNNING);
  to_slow_c: cover property (mode_q == power_mode_pkg::MODE_NORMAL ##1 mode_q == power_mode_pkg::MODE_SLOW);
  fast_ready_c: cover property ($rose(fast_rdy_q));

endmodule // power_mode_clock_controller

// >>> verification/cpu_osc_model.sv
// Purpose: far-side model: rc oscillator pins and the cpu's halt, wake and watchdog pulses
// Assumes: hclk period 8 ns; oscillator edges land on falling hclk edges, away from sampling
// Notes: fast pin period 8 hclk cycles, slow pin period 80 hclk cycles
`timescale 1ns/1ps
module cpu_osc_model (
  input wire logic hclk,
  input wire logic fast_osc_on,
  output logic fast_osc_pin,
  output logic slow_osc_pin,
  output logic halt_req,
  output logic wake_req,
  output logic clr_wdt_req,
  output logic wdt_timeout
);
  // ****************************************
  // oscillators
  // ****************************************
  initial begin
    fast_osc_pin = 1'b0;
    slow_osc_pin = 1'b0;
    {halt_req, wake_req, clr_wdt_req, wdt_timeout} = 4'h0;
  end
  // fast rc stands still low while disabled, never floats
  always #32 fast_osc_pin = fast_osc_on ? ~fast_osc_pin : 1'b0;
  // slow rc has no disable at all
  always #320 slow_osc_pin = ~slow_osc_pin;
  // ****************************************
  // cpu pulses
  // ****************************************
  // one-cycle pulse: 0 halt, 1 wake, 2 clear watchdog, 3 watchdog time-out
  task automatic pulse(input int kind);
    @(posedge hclk);
    case (kind)
      0: halt_req <= 1'b1;
      1: wake_req <= 1'b1;
      2: clr_wdt_req <= 1'b1;
      default: wdt_timeout <= 1'b1;
    endcase
    @(posedge hclk);
    {halt_req, wake_req, clr_wdt_req, wdt_timeout} <= 4'h0;
  endtask
endmodule // cpu_osc_model

// >>> verification/power_mode_clock_controller_bench.sv
// Purpose: self-checking bench for the power mode clock controller
// Assumes: zero-wait ahb-lite slave; ce dropped only once, with no transfer in flight
// Notes: tick spacing is measured in hclk cycles from the model's pin periods
`timescale 1ns/1ps
module power_mode_clock_controller_bench;
  // ****************************************
  // signals
  // ****************************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  power_mode_pkg::mode_e lp; // expected low-power mode
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, fast_pin, slow_pin, halt_req, wake_req, clr_wdt_req, wdt_timeout;
  logic [31:0] hrdata, rd;
  power_mode_pkg::clock_ctrl_s clk_ctrl;
  power_mode_pkg::mode_e mode;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int gap;
  always #4 hclk = ~hclk;
  power_mode_clock_controller dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fast_osc_pin(fast_pin),
    .slow_osc_pin(slow_pin), .halt_req(halt_req), .wake_req(wake_req), .clr_wdt_req(clr_wdt_req),
    .wdt_timeout(wdt_timeout), .clk_ctrl(clk_ctrl), .mode(mode));
  cpu_osc_model cpu (.hclk(hclk), .fast_osc_on(clk_ctrl.fast_osc_on), .fast_osc_pin(fast_pin),
    .slow_osc_pin(slow_pin), .halt_req(halt_req), .wake_req(wake_req), .clr_wdt_req(clr_wdt_req),
    .wdt_timeout(wdt_timeout));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // single word transfer; address phase held until hready, data taken at the next hready edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    check("hresp", hresp, 1'b0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  // cycles between two sys_tick pulses; the first pulse seen is skipped to let a switch settle
  task automatic tick_gap(output int g);
    repeat (2) do @(posedge hclk); while (clk_ctrl.sys_tick !== 1'b1);
    g = 0;
    do begin @(posedge hclk); g++; end while (clk_ctrl.sys_tick !== 1'b1 && g < 4000);
  endtask
  task automatic wait_mode(input power_mode_pkg::mode_e m);
    for (int i = 0; i < 3000 && mode !== m; i++) @(posedge hclk);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, far above the few tens of thousands of cycles the tests need
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      results();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check("reset clk_ctrl", clk_ctrl, 7'h7c);
    check("reset mode", mode, power_mode_pkg::MODE_NORMAL);
    bus(1'b0, 32'h0, 32'h0, rd);
    check("reset clock mode", rd, 32'h3);
    bus(1'b0, 32'h4, 32'h0, rd);
    check("reset control", rd, 32'h0);
    bus(1'b0, 32'h8, 32'h0, rd);
    check("reset status", rd, 32'h0);
    bus(1'b0, 32'hc, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    // fast ready may not rise before 1024 fast edges of 8 cycles
    repeat (7800) @(posedge hclk);
    bus(1'b0, 32'h0, 32'h0, rd);
    check("fast ready early", rd[2], 1'b0);
    repeat (700) @(posedge hclk);
    bus(1'b0, 32'h0, 32'h0, rd);
    check("fast ready", rd[3:2], 2'h3);
    tick_gap(gap);
    check("fast /1 tick", gap, 8);
    // divider codes 010..111 give fast/64 down to fast/2
    for (int c = 2; c < 8; c++) begin
      wr(32'h0, (c << 5) | 32'h2);
      tick_gap(gap);
      check("divided tick", gap, 8 << (8 - c));
      check("still normal", mode, power_mode_pkg::MODE_NORMAL);
    end
    // both slow codes, each followed by a return through a different route
    for (int c = 0; c < 2; c++) begin
      wr(32'h0, (c << 5) | 32'h2);
      wait_mode(power_mode_pkg::MODE_SLOW);
      check("slow mode", mode, power_mode_pkg::MODE_SLOW);
      check("fast osc off", clk_ctrl.fast_osc_on, 1'b0);
      tick_gap(gap);
      check("slow tick", gap, 80);
      bus(1'b0, 32'h0, 32'h0, rd);
      check("slow ready, fast not", rd[3:2], 2'h2);
      wr(32'h0, c ? 32'h3 : 32'he2);
      wait_mode(power_mode_pkg::MODE_NORMAL);
      check("back to normal", mode, power_mode_pkg::MODE_NORMAL);
      check("fast osc on", clk_ctrl.fast_osc_on, 1'b1);
      for (int i = 0; i < 4000 && rd[2] !== 1'b1; i++) bus(1'b0, 32'h0, 32'h0, rd);
      check("fast ready polled", rd[2], 1'b1);
      tick_gap(gap);
      check("fast tick after return", gap, c ? 8 : 16);
    end
    // halt into sleep, idle stopped, idle running
    for (int i = 0; i < 3; i++) begin
      lp = (i == 0) ? power_mode_pkg::MODE_SLEEP : (i == 1) ? power_mode_pkg::MODE_IDLE_STOPPED
        : power_mode_pkg::MODE_IDLE_RUNNING;
      wr(32'h0, (i != 0) ? 32'h3 : 32'h1);
      wr(32'h4, (i == 2) ? 32'h80 : 32'h0);
      cpu.pulse(3);
      bus(1'b0, 32'h8, 32'h0, rd);
      check("expired flag set", rd[1], 1'b1);
      cpu.pulse(0);
      #1;
      check("low power mode", mode, lp);
      check("gating", clk_ctrl[6:2], (i == 0) ? 5'h2 : (i == 1) ? 5'h6 : 5'hf);
      gap = 0;
      repeat (3) begin @(posedge hclk); gap += clk_ctrl.wdt_clear; end
      check("watchdog clear pulses", gap, 1);
      cpu.pulse(0);
      #1;
      check("halt ignored", mode, lp);
      bus(1'b0, 32'h8, 32'h0, rd);
      check("status flags", rd, (32'(lp) << 2) | 32'h1);
      cpu.pulse(1);
      #1;
      check("woken", mode, power_mode_pkg::MODE_NORMAL);
      bus(1'b0, 32'h0, 32'h0, rd);
      check("settings held", rd & 32'he3, (i != 0) ? 32'h3 : 32'h1);
      bus(1'b0, 32'h4, 32'h0, rd);
      check("keep held", rd, (i == 2) ? 32'h80 : 32'h0);
      cpu.pulse(2);
      bus(1'b0, 32'h8, 32'h0, rd);
      check("power down cleared", rd, 32'h0);
    end
    // frozen: the bus stalls and a halt seen while frozen is lost
    ce <= 1'b0;
    cpu.pulse(0);
    #1;
    check("frozen bus", hreadyout, 1'b0);
    check("frozen mode", mode, power_mode_pkg::MODE_NORMAL);
    @(posedge hclk);
    ce <= 1'b1;
    bus(1'b0, 32'h8, 32'h0, rd);
    check("status after freeze", rd, 32'h0);
    results();
  end
endmodule // power_mode_clock_controller_bench
